// ---- shared/fprc_pkg.sv ----
package fprc_pkg;

  // register indices on the serial control port
  localparam logic [7:0] FPRC_FLASH_CTRL_ADDR = 8'h10;
  localparam logic [7:0] FPRC_PATTERN_CTRL_ADDR = 8'h11;
  localparam logic [7:0] FPRC_BANK1_CURRENT_ADDR = 8'h12;

  // flash driver control fields
  localparam int FPRC_FLASH_EN_BIT = 0;
  localparam int FPRC_FLASH_CUR_LSB = 1;
  localparam int FPRC_FLASH_DUR_LSB = 3;
  localparam int FPRC_FLASH_MOD_BIT = 5;

  // pattern generator control fields
  localparam int FPRC_INTENSITY_BIT = 0;
  localparam int FPRC_LOOP_BIT = 1;
  localparam int FPRC_RUN_BIT = 2;

  // bank-one current fields
  localparam int FPRC_BLUE_LSB = 0;
  localparam int FPRC_GREEN_LSB = 2;
  localparam int FPRC_RED_LSB = 4;

  // reset values
  localparam logic FPRC_BIT_RST = 1'h0;
  localparam logic [1:0] FPRC_SEL_RST = 2'h0;
  localparam logic [7:0] FPRC_BYTE_RST = 8'h00;

  // flash duration codes
  localparam logic [1:0] FPRC_DUR_200MS = 2'h0;
  localparam logic [1:0] FPRC_DUR_400MS = 2'h1;
  localparam logic [1:0] FPRC_DUR_600MS = 2'h2;
  localparam logic [1:0] FPRC_DUR_PIN = 2'h3;

  // timing
  localparam int FPRC_CLK_PERIOD_NS = 5;
  localparam int FPRC_FLASH_200_MS = 200;
  localparam int FPRC_FLASH_400_MS = 400;
  localparam int FPRC_FLASH_600_MS = 600;
  localparam int FPRC_FLASH_200_CYC = FPRC_FLASH_200_MS * 1000000 / FPRC_CLK_PERIOD_NS;
  localparam int FPRC_FLASH_400_CYC = FPRC_FLASH_400_MS * 1000000 / FPRC_CLK_PERIOD_NS;
  localparam int FPRC_FLASH_600_CYC = FPRC_FLASH_600_MS * 1000000 / FPRC_CLK_PERIOD_NS;
  localparam int FPRC_CNT_W = 32;

  // flash sequencer states, gray along idle-timed-done
  typedef enum logic [1:0] {
    FPRC_FL_IDLE = 2'h0,
    FPRC_FL_TIMED = 2'h1,
    FPRC_FL_DONE = 2'h3,
    FPRC_FL_HELD = 2'h2
  } fprc_flash_state_t;

endpackage

// ---- design/fprc_flash_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
module fprc_flash_timer import fprc_pkg::*; #(
  parameter int T200_CYC = FPRC_FLASH_200_CYC,
  parameter int T400_CYC = FPRC_FLASH_400_CYC,
  parameter int T600_CYC = FPRC_FLASH_600_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic enable,
  input wire logic [1:0] duration_sel,
  input wire logic pin_level,
  // drive
  output logic drive_on
);

  fprc_flash_state_t state_reg, state_next;
  logic [FPRC_CNT_W-1:0] count_reg;
  logic drive_reg;

  function automatic logic [FPRC_CNT_W-1:0] load_count(input logic [1:0] sel);
    case (sel)
      FPRC_DUR_400MS: load_count = FPRC_CNT_W'(T400_CYC);
      FPRC_DUR_600MS: load_count = FPRC_CNT_W'(T600_CYC);
      default: load_count = FPRC_CNT_W'(T200_CYC);
    endcase
  endfunction

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FPRC_FL_IDLE: begin
        if (enable) begin
          state_next = (duration_sel == FPRC_DUR_PIN) ? FPRC_FL_HELD : FPRC_FL_TIMED;
        end
      end
      FPRC_FL_TIMED: begin
        if (!enable) begin
          state_next = FPRC_FL_IDLE;
        end else if (count_reg == FPRC_CNT_W'(1)) begin
          state_next = FPRC_FL_DONE;
        end
      end
      FPRC_FL_HELD: begin
        if (!enable) begin
          state_next = FPRC_FL_IDLE;
        end
      end
      FPRC_FL_DONE: begin
        // one flash per arming; software clears enable to re-arm
        if (!enable) begin
          state_next = FPRC_FL_IDLE;
        end
      end
      default: state_next = FPRC_FL_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= FPRC_FL_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // R3: timed flash length
  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= '0;
    end else if (state_reg == FPRC_FL_IDLE) begin
      count_reg <= load_count(duration_sel);
    end else if (state_reg == FPRC_FL_TIMED) begin
      count_reg <= count_reg - FPRC_CNT_W'(1);
    end
  end

  // R1: driver follows enable and sequence
  always_ff @(posedge clk) begin
    if (rst) begin
      drive_reg <= FPRC_BIT_RST;
    end else begin
      drive_reg <= (state_next == FPRC_FL_TIMED) || ((state_next == FPRC_FL_HELD) && pin_level);
    end
  end

  assign drive_on = drive_reg;

  property p_timed_drive;
    @(posedge clk) disable iff (rst)
    (state_reg == FPRC_FL_TIMED) |-> drive_reg;
  endproperty
  a_timed_drive: assert property (p_timed_drive) // R3
    else $error("flash not driven during timed flash");

  property p_held_follows_pin;
    @(posedge clk) disable iff (rst)
    (state_reg == FPRC_FL_HELD) |-> (drive_reg == $past(pin_level));
  endproperty
  a_held_follows_pin: assert property (p_held_follows_pin) // R3
    else $error("held flash does not follow pin");

  property p_done_dark;
    @(posedge clk) disable iff (rst)
    (state_reg == FPRC_FL_DONE) |-> !drive_reg;
  endproperty
  a_done_dark: assert property (p_done_dark) // R3
    else $error("flash driven after timeout");

  c_held: cover property (@(posedge clk) disable iff (rst) state_reg == FPRC_FL_HELD && drive_reg);
  c_timeout: cover property (@(posedge clk) disable iff (rst) state_reg == FPRC_FL_DONE);

endmodule
`default_nettype wire

// ---- design/fprc_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// R1: flash enable bit 0 switches the high-current flash driver off at 0 and on at 1.
// R2: flash current field bits 2-1 picks a quarter, half, three quarters or full flash current.
// R3: flash duration field gives 200, 400 or 600 ms flashes, and code 11 follows the flash pin.
// R4: flash modulation bit turns the flash driver modulation off at 0 and on at 1.
// R5: setting the pattern run bit starts the pattern from its first command slot; a run write on the end of a single pass keeps run set with no restart.
// R6: with the pattern run bit clear the pattern generator executes nothing.
// R7: with the repeat bit clear the pattern runs once and then stops.
// R8: with the repeat bit set the pattern repeats until software stops it.
// R9: the intensity curve bit chooses intensity mode 0 or mode 1.
// R10: red bank-one current field bits 5-4 picks a quarter to full current.
// R11: green bank-one current field bits 3-2 picks a quarter to full current.
// R12: blue bank-one current field bits 1-0 picks a quarter to full current.
// R13: unused upper bits read zero and ignore writes, and every field resets to zero.
module fprc_regs import fprc_pkg::*; #(
  parameter int T200_CYC = FPRC_FLASH_200_CYC,
  parameter int T400_CYC = FPRC_FLASH_400_CYC,
  parameter int T600_CYC = FPRC_FLASH_600_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // register port from the serial control interface
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data,
  output logic reg_rd_valid,
  // flash pin and flash driver
  input wire logic flash_pin,
  output logic flash_drive_on,
  output logic [1:0] flash_current_sel,
  output logic flash_modulation_enable,
  // pattern generator
  input wire logic pattern_end,
  output logic pattern_run,
  output logic pattern_restart,
  output logic pattern_loop,
  output logic intensity_mode,
  // bank-one current limits
  output logic [1:0] red_bank1_current_sel,
  output logic [1:0] green_bank1_current_sel,
  output logic [1:0] blue_bank1_current_sel
);

  logic wr_flash, wr_pattern, wr_bank1;
  logic flash_en_reg;
  logic [1:0] flash_cur_reg, flash_dur_reg;
  logic flash_mod_reg;
  logic run_reg, loop_reg, intensity_reg, restart_reg;
  logic [1:0] red_reg, green_reg, blue_reg;
  logic [7:0] rd_data_reg;
  logic rd_valid_reg;
  logic pin_meta_reg, pin_sync_reg;
  logic run_set, run_next;
  logic restart_next;
  logic flash_drive;

  assign wr_flash = reg_wr_en && (reg_addr == FPRC_FLASH_CTRL_ADDR);
  assign wr_pattern = reg_wr_en && (reg_addr == FPRC_PATTERN_CTRL_ADDR);
  assign wr_bank1 = reg_wr_en && (reg_addr == FPRC_BANK1_CURRENT_ADDR);

  // flash pin is asynchronous to clk
  always_ff @(posedge clk) begin
    if (rst) begin
      pin_meta_reg <= FPRC_BIT_RST;
      pin_sync_reg <= FPRC_BIT_RST;
    end else begin
      pin_meta_reg <= flash_pin;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // R2 R4 R13: flash fields, reset zero
  always_ff @(posedge clk) begin
    if (rst) begin
      flash_en_reg <= FPRC_BIT_RST;
      flash_cur_reg <= FPRC_SEL_RST;
      flash_dur_reg <= FPRC_SEL_RST;
      flash_mod_reg <= FPRC_BIT_RST;
    end else if (wr_flash) begin
      flash_en_reg <= reg_wr_data[FPRC_FLASH_EN_BIT];
      flash_cur_reg <= reg_wr_data[FPRC_FLASH_CUR_LSB +: 2];
      flash_dur_reg <= reg_wr_data[FPRC_FLASH_DUR_LSB +: 2];
      flash_mod_reg <= reg_wr_data[FPRC_FLASH_MOD_BIT];
    end
  end

  // R1: driver sequencing
  fprc_flash_timer #(
    .T200_CYC(T200_CYC),
    .T400_CYC(T400_CYC),
    .T600_CYC(T600_CYC)
  ) u_flash_timer (
    .clk(clk),
    .rst(rst),
    .enable(flash_en_reg),
    .duration_sel(flash_dur_reg),
    .pin_level(pin_sync_reg),
    .drive_on(flash_drive)
  );

  // software setting run wins over a same-cycle end of a single pass
  assign run_set = wr_pattern && reg_wr_data[FPRC_RUN_BIT];

  always_comb begin
    run_next = run_reg;
    restart_next = 1'h0;
    if (wr_pattern) begin
      run_next = reg_wr_data[FPRC_RUN_BIT];
    end
    // R7: single pass clears run
    if (run_reg && pattern_end && !loop_reg && !run_set) begin
      run_next = 1'h0;
    end
    // R5: start from first slot
    if (run_next && !run_reg) begin
      restart_next = 1'h1;
    end
    // R8: loop back to first slot
    if (run_reg && run_next && pattern_end && loop_reg) begin
      restart_next = 1'h1;
    end
  end

  // R6: run state
  always_ff @(posedge clk) begin
    if (rst) begin
      run_reg <= FPRC_BIT_RST;
      restart_reg <= FPRC_BIT_RST;
    end else begin
      run_reg <= run_next;
      restart_reg <= restart_next;
    end
  end

  // R9: mode and loop bits
  always_ff @(posedge clk) begin
    if (rst) begin
      loop_reg <= FPRC_BIT_RST;
      intensity_reg <= FPRC_BIT_RST;
    end else if (wr_pattern) begin
      loop_reg <= reg_wr_data[FPRC_LOOP_BIT];
      intensity_reg <= reg_wr_data[FPRC_INTENSITY_BIT];
    end
  end

  // R10 R11 R12: bank-one current fields
  always_ff @(posedge clk) begin
    if (rst) begin
      red_reg <= FPRC_SEL_RST;
      green_reg <= FPRC_SEL_RST;
      blue_reg <= FPRC_SEL_RST;
    end else if (wr_bank1) begin
      red_reg <= reg_wr_data[FPRC_RED_LSB +: 2];
      green_reg <= reg_wr_data[FPRC_GREEN_LSB +: 2];
      blue_reg <= reg_wr_data[FPRC_BLUE_LSB +: 2];
    end
  end

  // R13: readback, unused bits zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_reg <= FPRC_BYTE_RST;
      rd_valid_reg <= FPRC_BIT_RST;
    end else begin
      rd_valid_reg <= reg_rd_en;
      if (reg_rd_en) begin
        case (reg_addr)
          FPRC_FLASH_CTRL_ADDR:
            rd_data_reg <= {2'h0, flash_mod_reg, flash_dur_reg, flash_cur_reg, flash_en_reg};
          FPRC_PATTERN_CTRL_ADDR:
            rd_data_reg <= {5'h00, run_reg, loop_reg, intensity_reg};
          FPRC_BANK1_CURRENT_ADDR:
            rd_data_reg <= {2'h0, red_reg, green_reg, blue_reg};
          default:
            rd_data_reg <= FPRC_BYTE_RST;
        endcase
      end
    end
  end

  assign reg_rd_data = rd_data_reg;
  assign reg_rd_valid = rd_valid_reg;
  assign flash_drive_on = flash_drive;
  assign flash_current_sel = flash_cur_reg;
  assign flash_modulation_enable = flash_mod_reg;
  assign pattern_run = run_reg;
  assign pattern_restart = restart_reg;
  assign pattern_loop = loop_reg;
  assign intensity_mode = intensity_reg;
  assign red_bank1_current_sel = red_reg;
  assign green_bank1_current_sel = green_reg;
  assign blue_bank1_current_sel = blue_reg;

  property p_flash_off;
    @(posedge clk) disable iff (rst)
    !flash_en_reg |=> !flash_drive_on;
  endproperty
  a_flash_off: assert property (p_flash_off) // R1
    else $error("flash driven while disabled");

  property p_flash_current;
    @(posedge clk) disable iff (rst)
    wr_flash |=> (flash_current_sel == $past(reg_wr_data[2:1]));
  endproperty
  a_flash_current: assert property (p_flash_current) // R2
    else $error("flash current field not taken");

  property p_flash_start;
    @(posedge clk) disable iff (rst)
    (wr_flash && reg_wr_data[0] && reg_wr_data[4:3] != 2'h3 && !flash_en_reg)
      |=> ##1 flash_drive_on [*2];
  endproperty
  a_flash_start: assert property (p_flash_start) // R3
    else $error("timed flash did not start");

  property p_flash_mod;
    @(posedge clk) disable iff (rst)
    wr_flash |=> (flash_modulation_enable == $past(reg_wr_data[5]));
  endproperty
  a_flash_mod: assert property (p_flash_mod) // R4
    else $error("flash modulation bit not taken");

  property p_start;
    @(posedge clk) disable iff (rst)
    $rose(pattern_run) |-> pattern_restart;
  endproperty
  a_start: assert property (p_start) // R5
    else $error("pattern start without restart");

  property p_idle;
    @(posedge clk) disable iff (rst)
    !pattern_run |-> !pattern_restart;
  endproperty
  a_idle: assert property (p_idle) // R6
    else $error("restart while generator disabled");

  property p_single;
    @(posedge clk) disable iff (rst)
    (pattern_run && pattern_end && !pattern_loop && !wr_pattern) |=> !pattern_run;
  endproperty
  a_single: assert property (p_single) // R7
    else $error("single pass did not stop");

  property p_loop;
    @(posedge clk) disable iff (rst)
    (pattern_run && pattern_end && pattern_loop && !wr_pattern) |=> pattern_run && pattern_restart;
  endproperty
  a_loop: assert property (p_loop) // R8
    else $error("loop did not restart");

  property p_mode;
    @(posedge clk) disable iff (rst)
    wr_pattern |=> (intensity_mode == $past(reg_wr_data[0]));
  endproperty
  a_mode: assert property (p_mode) // R9
    else $error("intensity mode not taken");

  property p_red;
    @(posedge clk) disable iff (rst)
    wr_bank1 |=> (red_bank1_current_sel == $past(reg_wr_data[5:4]));
  endproperty
  a_red: assert property (p_red) // R10
    else $error("red current field not taken");

  property p_green;
    @(posedge clk) disable iff (rst)
    wr_bank1 |=> (green_bank1_current_sel == $past(reg_wr_data[3:2]));
  endproperty
  a_green: assert property (p_green) // R11
    else $error("green current field not taken");

  property p_blue;
    @(posedge clk) disable iff (rst)
    wr_bank1 |=> (blue_bank1_current_sel == $past(reg_wr_data[1:0]));
  endproperty
  a_blue: assert property (p_blue) // R12
    else $error("blue current field not taken");

  property p_upper_zero;
    @(posedge clk) disable iff (rst)
    (reg_rd_en && reg_addr != FPRC_FLASH_CTRL_ADDR) |=> (reg_rd_data[7:6] == 2'h0) && reg_rd_valid;
  endproperty
  a_upper_zero: assert property (p_upper_zero) // R13
    else $error("unused bits read nonzero");

  c_single_pass: cover property (@(posedge clk) disable iff (rst)
    pattern_run && pattern_end && !pattern_loop);
  c_loop_pass: cover property (@(posedge clk) disable iff (rst)
    pattern_run && pattern_end && pattern_loop);
  c_flash_on: cover property (@(posedge clk) disable iff (rst) flash_drive_on);

endmodule
`default_nettype wire

// ---- dv/fprc_regs_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module fprc_regs_test import fprc_pkg::*;;
  localparam int T200 = 20;
  localparam int T400 = 40;
  localparam int T600 = 60;
  logic clk, rst;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
  logic reg_wr_en, reg_rd_en, reg_rd_valid;
  logic flash_pin, flash_drive_on, flash_modulation_enable;
  logic [1:0] flash_current_sel;
  logic pattern_end, pattern_run, pattern_restart, pattern_loop, intensity_mode;
  logic [1:0] red_bank1_current_sel, green_bank1_current_sel, blue_bank1_current_sel;
  logic [7:0] model [3];
  int failures, tests_run, cycles;

  fprc_regs #(.T200_CYC(T200), .T400_CYC(T400), .T600_CYC(T600)) dut_u (
    .clk(clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
    .flash_pin(flash_pin), .flash_drive_on(flash_drive_on),
    .flash_current_sel(flash_current_sel), .flash_modulation_enable(flash_modulation_enable),
    .pattern_end(pattern_end), .pattern_run(pattern_run), .pattern_restart(pattern_restart),
    .pattern_loop(pattern_loop), .intensity_mode(intensity_mode),
    .red_bank1_current_sel(red_bank1_current_sel),
    .green_bank1_current_sel(green_bank1_current_sel),
    .blue_bank1_current_sel(blue_bank1_current_sel)
  );

  always #2.5 clk = ~clk;

  // writable bits of each mapped register, nothing elsewhere
  function automatic logic [7:0] mask_of(input logic [7:0] a);
    if (a == FPRC_FLASH_CTRL_ADDR || a == FPRC_BANK1_CURRENT_ADDR) return 8'h3F;
    if (a == FPRC_PATTERN_CTRL_ADDR) return 8'h07;
    return 8'h00;
  endfunction

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(posedge clk);
    #1 reg_wr_en = 1'b0;
    if (mask_of(a) != 8'h00) model[a - FPRC_FLASH_CTRL_ADDR] = d & mask_of(a);
  endtask

  task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(posedge clk);
    #1 reg_rd_en = 1'b0;
    check("read valid", {7'h00, reg_rd_valid}, 8'h01);
    check("read data", reg_rd_data, exp);
  endtask

  task automatic check_fields();
    check("flash current", {6'h00, flash_current_sel}, {6'h00, model[0][2:1]});
    check("modulation", {7'h00, flash_modulation_enable}, {7'h00, model[0][5]});
    check("loop", {7'h00, pattern_loop}, {7'h00, model[1][1]});
    check("intensity", {7'h00, intensity_mode}, {7'h00, model[1][0]});
    check("red sel", {6'h00, red_bank1_current_sel}, {6'h00, model[2][5:4]});
    check("green sel", {6'h00, green_bank1_current_sel}, {6'h00, model[2][3:2]});
    check("blue sel", {6'h00, blue_bank1_current_sel}, {6'h00, model[2][1:0]});
  endtask

  task automatic pulse_end();
    pattern_end = 1'b1;
    @(posedge clk);
    #1 pattern_end = 1'b0;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles > 20000) begin
      failures++;
      report_and_stop();
    end
  end

  initial begin
    logic [7:0] a, d;
    int n;
    clk = 1'b0;
    rst = 1'b1;
    reg_addr = 8'h00;
    reg_wr_data = 8'h00;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    flash_pin = 1'b0;
    pattern_end = 1'b0;
    failures = 0;
    tests_run = 0;
    cycles = 0;
    model = '{8'h00, 8'h00, 8'h00};
    void'($urandom(53417));
    repeat (10) @(posedge clk);
    #1 rst = 1'b0;
    // reset values of all registers and of the field and run outputs
    for (int i = 0; i < 3; i++) begin
      rd_check(FPRC_FLASH_CTRL_ADDR + 8'(i), 8'h00);
      // one idle cycle so the read strobe is not lowered and raised at once
      @(posedge clk);
      #1;
    end
    check_fields();
    check("run at reset", {7'h00, pattern_run}, 8'h00);

    // random writes, reserved bits and unmapped addresses among them
    for (int i = 0; i < 40; i++) begin
      n = $urandom_range(0, 3);
      a = (n < 3) ? FPRC_FLASH_CTRL_ADDR + 8'(n) : 8'($urandom_range(8'h13, 8'hFF));
      d = 8'($urandom);
      if (i == 0) d = 8'hFF;
      // keep the run bit clear here; the pattern checks below own it
      if (a == FPRC_PATTERN_CTRL_ADDR) d[2] = 1'h0;
      wr(a, d);
      check_fields();
      rd_check(a, mask_of(a) & ((n < 3) ? model[n] : 8'h00));
    end
    @(posedge clk);
    #1 rd_check(8'h00, 8'h00);

    // end of pattern while stopped does nothing
    pulse_end();
    check("idle restart", {7'h00, pattern_restart}, 8'h00);
    check("idle run", {7'h00, pattern_run}, 8'h00);
    // single pass
    wr(FPRC_PATTERN_CTRL_ADDR, 8'h04);
    check("start restart", {7'h00, pattern_restart}, 8'h01);
    check("start run", {7'h00, pattern_run}, 8'h01);
    @(posedge clk);
    #1 check("restart width", {7'h00, pattern_restart}, 8'h00);
    pulse_end();
    check("single stop", {7'h00, pattern_run}, 8'h00);
    rd_check(FPRC_PATTERN_CTRL_ADDR, 8'h00);
    // looping until software clears the run bit
    wr(FPRC_PATTERN_CTRL_ADDR, 8'h07);
    @(posedge clk);
    #1 pulse_end();
    check("loop restart", {7'h00, pattern_restart}, 8'h01);
    check("loop run", {7'h00, pattern_run}, 8'h01);
    wr(FPRC_PATTERN_CTRL_ADDR, 8'h03);
    check("loop stopped", {7'h00, pattern_run}, 8'h00);

    // timed flashes for each timed duration code, 0 to 2
    for (int c = 0; c < 3; c++) begin
      wr(FPRC_FLASH_CTRL_ADDR, 8'h00);
      repeat (3) @(posedge clk);
      #1 wr(FPRC_FLASH_CTRL_ADDR, 8'((c << 3) | 1));
      check("flash early", {7'h00, flash_drive_on}, 8'h00);
      @(posedge clk);
      #1 check("flash on", {7'h00, flash_drive_on}, 8'h01);
      n = 0;
      while (flash_drive_on === 1'b1 && n < 200) begin
        @(posedge clk);
        #1 n++;
      end
      // one cycle of slack for where the timer starts counting
      check("flash length ok", {7'h00, 1'(n >= T200 * (c + 1) - 1 && n <= T200 * (c + 1) + 1)},
            8'h01);
    end

    // pin-held flash, then enable cleared while on
    wr(FPRC_FLASH_CTRL_ADDR, 8'h00);
    repeat (3) @(posedge clk);
    #1 wr(FPRC_FLASH_CTRL_ADDR, 8'h19);
    repeat (8) @(posedge clk);
    #1 check("pin low", {7'h00, flash_drive_on}, 8'h00);
    flash_pin = 1'b1;
    repeat (8) @(posedge clk);
    #1 check("pin high", {7'h00, flash_drive_on}, 8'h01);
    flash_pin = 1'b0;
    repeat (8) @(posedge clk);
    #1 check("pin released", {7'h00, flash_drive_on}, 8'h00);
    flash_pin = 1'b1;
    repeat (8) @(posedge clk);
    #1 wr(FPRC_FLASH_CTRL_ADDR, 8'h18);
    @(posedge clk);
    #1 check("disabled", {7'h00, flash_drive_on}, 8'h00);
    flash_pin = 1'b0;
    report_and_stop();
  end
endmodule
`default_nettype wire
